//--- usart_consts.svh
// Purpose: register indices, field positions, reset values and counts for the serial core
// Assumes: word-wide bus, byte address = index * 4
// Notes: definitions only
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH

// Register indices; the bus address is the index times four
`define IDX_TX_HOLDING 12'h0B8
`define IDX_RX_HOLDING 12'h0B9
`define IDX_CTRL_STATUS 12'h0BA
`define IDX_RX_STATUS 12'h0BB
`define IDX_IRQ_CLOCK 12'h0BC
`define IDX_BAUD_CFG 12'h0BD

// serial_control_status fields
`define CS_PARITY_ON 7
`define CS_PARITY_SEL_HI 6
`define CS_PARITY_SEL_LO 5
`define CS_CHAR_LEN_HI 4
`define CS_CHAR_LEN_LO 3
`define CS_ERROR 2
`define CS_RX_FULL 1
`define CS_TX_EMPTY 0

// serial_receive_status fields
`define RS_OVERRUN 7
`define RS_FRAMING 6
`define RS_PARITY 5
`define RS_BREAK 4
`define RS_RX_NINTH 3
`define RS_ATTENTION 2
`define RS_TX_ACTIVE 1
`define RS_LINE_FAULT 0

// serial_irq_clock_source fields
`define IC_TWO_STOP 7
`define IC_FORCE_BREAK 6
`define IC_TX_PIN_EN 5
`define IC_SYNC_MODE 4
`define IC_RX_EXT_CLK 3
`define IC_TX_EXT_CLK 2
`define IC_RX_IRQ_EN 1
`define IC_TX_IRQ_EN 0

// baud configuration fields
`define BC_CLK_DRIVE 16
`define BAUD_DIV_RESET 11'h001

// Oversampling: ticks per bit in asynchronous mode, and the half-bit point
`define OVERSAMPLE_LAST 4'hF
`define HALF_BIT_TICK 4'h7
`define VOTE_FIRST 4'h7
`define VOTE_MID 4'h8
`define VOTE_LAST 4'h9

`endif

//--- usart_pkg.sv
// Purpose: types shared by the serial core
// Assumes: constants come from usart_consts.svh
// Notes: the whole module state is one packed struct
package usart_pkg;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;

  typedef struct packed {
    logic parity_on;
    logic parity_sel_hi;
    logic tx_ninth_bit;
    logic char_len_hi;
    logic char_len_lo;
    logic rx_full_flag;
    logic tx_empty_flag;
    logic overrun_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic line_break_flag;
    logic rx_ninth_bit;
    logic attention_enable;
    logic tx_active_flag;
    logic rx_line_fault_flag;
    logic two_stop_sel;
    logic force_line_break;
    logic tx_pin_enable;
    logic sync_mode;
    logic rx_ext_clock_sel;
    logic tx_ext_clock_sel;
    logic rx_irq_enable;
    logic tx_irq_enable;
    logic [10:0] baud_divisor;
    logic ckx_drive;
    logic [7:0] tx_holding_buffer;
    logic [7:0] rx_holding_buffer;
    logic [11:0] tx_shift_reg;
    logic [3:0] tx_bits_left;
    logic [3:0] tx_sub;
    tx_state_t tx_state;
    logic [10:0] rx_shift_reg;
    logic [3:0] rx_bit_idx;
    logic [3:0] rx_sub;
    logic [1:0] rx_votes;
    rx_state_t rx_state;
    logic [10:0] baud_cnt;
    logic baud_clk;
    logic rx_sync1;
    logic rx_sync2;
    logic ck_sync1;
    logic ck_sync2;
    logic ck_sync3;
    logic dp_write;
    logic [11:0] dp_index;
    logic [31:0] hrdata;
  } state_t;

endpackage : usart_pkg

//--- usart_control_status_core.sv
// Purpose: full-duplex serial transceiver with its control and status registers
// Assumes: AHB-Lite slave, zero wait states, word accesses only
// Notes: one clock; the receive and external clock pins pass a two-stage synchroniser
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`include "usart_consts.svh"

module usart_control_status_core
  import usart_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic port_pin_value,
  input wire logic ext_baud_clock_pin_in,
  output logic ext_baud_clock_pin_out,
  output logic ext_baud_clock_pin_oe_n,
  output logic rx_irq,
  output logic tx_irq
);

  state_t q;
  state_t next_q;
  logic char_done;
  logic txd;
  logic rd_status;
  logic rd_rxbuf;
  logic ninth_in;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [3:0] data_len(input logic hi, input logic lo);
    if (hi) begin
      return 4'h9;
    end
    return lo ? 4'h7 : 4'h8;
  endfunction : data_len

  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] len,
                                     input logic hi, input logic lo);
    logic x;
    x = (len == 4'h7) ? ^d[6:0] : ^d[7:0];
    unique case ({hi, lo})
      2'b00: return ~x;
      2'b01: return x;
      2'b10: return 1'b1;
      2'b11: return 1'b0;
    endcase
  endfunction : parity_of

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic ap;
    logic [11:0] idx;
    logic [3:0] len;
    logic par_en;
    logic int_tick;
    logic ck_rise;
    logic ck_fall;
    logic tx_tick;
    logic rx_tick;
    logic rx_in;
    logic take;
    logic bit_val;
    logic [1:0] vsum;
    logic [11:0] frame;
    logic [10:0] rcv;
    logic [8:0] data;
    logic [31:0] rdata;
    next_q = q;
    char_done = 1'b0;
    ninth_in = 1'b0;
    ap = hsel && htrans[1] && hready;
    idx = haddr[13:2];
    len = data_len(q.char_len_hi, q.char_len_lo);
    par_en = q.parity_on && (len != 4'h9);
    take = 1'b0;
    bit_val = 1'b0;
    vsum = 2'b00;
    frame = 12'hFFF;
    rcv = q.rx_shift_reg;
    data = 9'h000;
    rdata = 32'h0000_0000;
    int_tick = 1'b0;
    ck_rise = 1'b0;
    ck_fall = 1'b0;
    tx_tick = 1'b0;
    rx_tick = 1'b0;
    rx_in = 1'b1;

    // Pin synchronisers
    next_q.rx_sync1 = rx_pin;
    next_q.rx_sync2 = q.rx_sync1;
    next_q.ck_sync1 = ext_baud_clock_pin_in;
    next_q.ck_sync2 = q.ck_sync1;
    next_q.ck_sync3 = q.ck_sync2;
    ck_rise = q.ck_sync2 && !q.ck_sync3;
    ck_fall = !q.ck_sync2 && q.ck_sync3;

    // Baud generator; a zero divisor stops the internal clock to save power
    if (q.baud_divisor == 11'h000) begin
      next_q.baud_cnt = 11'h000;
    end else if (q.baud_cnt >= q.baud_divisor - 11'h001) begin
      next_q.baud_cnt = 11'h000;
      next_q.baud_clk = !q.baud_clk;
      int_tick = 1'b1;
    end else begin
      next_q.baud_cnt = q.baud_cnt + 11'h001;
    end
    tx_tick = q.tx_ext_clock_sel ? ck_rise : int_tick;
    // Synchronous receive samples on the falling edge of an external clock
    rx_tick = q.rx_ext_clock_sel ? (q.sync_mode ? ck_fall : ck_rise) : int_tick;

    // Loopback feeds the receiver straight from the transmit line
    txd = q.force_line_break ? 1'b0 : ((q.tx_state == TX_SEND) ? q.tx_shift_reg[0] : 1'b1);
    rx_in = (q.char_len_hi && q.char_len_lo) ? txd : q.rx_sync2;

    // Bus write data phase
    if (q.dp_write) begin
      unique case (q.dp_index)
        `IDX_TX_HOLDING: begin
          next_q.tx_holding_buffer = hwdata[7:0];
          next_q.tx_empty_flag = 1'b0;
        end
        `IDX_CTRL_STATUS: begin
          next_q.parity_on = hwdata[`CS_PARITY_ON];
          next_q.parity_sel_hi = hwdata[`CS_PARITY_SEL_HI];
          next_q.tx_ninth_bit = hwdata[`CS_PARITY_SEL_LO];
          next_q.char_len_hi = hwdata[`CS_CHAR_LEN_HI];
          next_q.char_len_lo = hwdata[`CS_CHAR_LEN_LO];
        end
        `IDX_RX_STATUS: next_q.attention_enable = hwdata[`RS_ATTENTION];
        `IDX_IRQ_CLOCK: begin
          next_q.two_stop_sel = hwdata[`IC_TWO_STOP];
          next_q.force_line_break = hwdata[`IC_FORCE_BREAK];
          next_q.tx_pin_enable = hwdata[`IC_TX_PIN_EN];
          next_q.sync_mode = hwdata[`IC_SYNC_MODE];
          next_q.rx_ext_clock_sel = hwdata[`IC_RX_EXT_CLK];
          next_q.tx_ext_clock_sel = hwdata[`IC_TX_EXT_CLK];
          next_q.rx_irq_enable = hwdata[`IC_RX_IRQ_EN];
          next_q.tx_irq_enable = hwdata[`IC_TX_IRQ_EN];
        end
        `IDX_BAUD_CFG: begin
          next_q.baud_divisor = hwdata[10:0];
          next_q.ckx_drive = hwdata[`BC_CLK_DRIVE];
        end
        default: ;
      endcase
    end

    // Bus read: data is taken from the post-write state so a write is never shadowed
    rd_status = ap && !hwrite && (idx == `IDX_RX_STATUS);
    rd_rxbuf = ap && !hwrite && (idx == `IDX_RX_HOLDING);
    if (ap && !hwrite) begin
      unique case (idx)
        `IDX_TX_HOLDING: rdata[7:0] = next_q.tx_holding_buffer;
        `IDX_RX_HOLDING: rdata[7:0] = next_q.rx_holding_buffer;
        `IDX_CTRL_STATUS: rdata[7:0] = {next_q.parity_on, next_q.parity_sel_hi,
          next_q.tx_ninth_bit, next_q.char_len_hi, next_q.char_len_lo,
          next_q.overrun_flag | next_q.framing_error_flag |
          next_q.parity_error_flag | next_q.line_break_flag,
          next_q.rx_full_flag, next_q.tx_empty_flag};
        `IDX_RX_STATUS: rdata[7:0] = {next_q.overrun_flag, next_q.framing_error_flag,
          next_q.parity_error_flag, next_q.line_break_flag, next_q.rx_ninth_bit,
          next_q.attention_enable, next_q.tx_active_flag, next_q.rx_line_fault_flag};
        `IDX_IRQ_CLOCK: rdata[7:0] = {next_q.two_stop_sel, next_q.force_line_break,
          next_q.tx_pin_enable, next_q.sync_mode, next_q.rx_ext_clock_sel,
          next_q.tx_ext_clock_sel, next_q.rx_irq_enable, next_q.tx_irq_enable};
        `IDX_BAUD_CFG: rdata = {15'h0000, next_q.ckx_drive, 5'h00, next_q.baud_divisor};
        default: ;
      endcase
      next_q.hrdata = rdata;
    end
    next_q.dp_write = ap && hwrite;
    next_q.dp_index = idx;

    // Read side effects come first so that an event in the same cycle wins
    if (rd_rxbuf) begin
      next_q.rx_full_flag = 1'b0;
    end
    if (rd_status) begin
      next_q.overrun_flag = 1'b0;
      next_q.framing_error_flag = 1'b0;
      next_q.parity_error_flag = 1'b0;
      next_q.line_break_flag = 1'b0;
    end
    if (rx_in) begin
      next_q.rx_line_fault_flag = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter; the engine sees the buffer one cycle after the write
    frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < len) begin
        frame[i + 1] = (i == 8) ? q.tx_ninth_bit : q.tx_holding_buffer[i];
      end
    end
    if (par_en) begin
      frame[len + 4'h1] = parity_of({1'b0, q.tx_holding_buffer}, len,
                                    q.parity_sel_hi, q.tx_ninth_bit);
    end
    unique case (q.tx_state)
      TX_IDLE: begin
        if (!q.tx_empty_flag) begin
          next_q.tx_shift_reg = frame;
          next_q.tx_bits_left = len + {3'b000, par_en} + 4'h1 + {3'b000, q.two_stop_sel};
          next_q.tx_sub = 4'h0;
          next_q.tx_state = TX_SEND;
          next_q.tx_empty_flag = 1'b1;
          next_q.tx_active_flag = 1'b1;
        end
      end
      TX_SEND: begin
        if (tx_tick) begin
          next_q.tx_sub = q.tx_sub + 4'h1;
          if (q.sync_mode || q.tx_sub == `OVERSAMPLE_LAST) begin
            next_q.tx_sub = 4'h0;
            if (q.tx_bits_left != 4'h0) begin
              next_q.tx_shift_reg = {1'b1, q.tx_shift_reg[11:1]};
              next_q.tx_bits_left = q.tx_bits_left - 4'h1;
            end else if (!q.tx_empty_flag) begin
              next_q.tx_shift_reg = frame;
              next_q.tx_bits_left = len + {3'b000, par_en} + 4'h1 + {3'b000, q.two_stop_sel};
              next_q.tx_empty_flag = 1'b1;
            end else begin
              next_q.tx_state = TX_IDLE;
              next_q.tx_active_flag = 1'b0;
            end
          end
        end
      end
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // Receiver
    if (rx_tick) begin
      unique case (q.rx_state)
        RX_IDLE: begin
          if (!rx_in) begin
            next_q.rx_shift_reg = 11'h000;
            next_q.rx_votes = 2'b00;
            next_q.rx_sub = 4'h0;
            if (q.sync_mode) begin
              next_q.rx_state = RX_DATA;
              next_q.rx_bit_idx = 4'h1;
            end else begin
              next_q.rx_state = RX_START;
            end
          end
        end
        RX_START: begin
          next_q.rx_sub = q.rx_sub + 4'h1;
          if (q.rx_sub == `HALF_BIT_TICK) begin
            next_q.rx_state = rx_in ? RX_IDLE : RX_DATA;
            next_q.rx_sub = `VOTE_MID;
            next_q.rx_bit_idx = 4'h0;
          end
        end
        RX_DATA: begin
          next_q.rx_sub = q.rx_sub + 4'h1;
          vsum = q.rx_votes + {1'b0, rx_in};
          if (q.rx_bit_idx != 4'h0 &&
              (q.rx_sub == `VOTE_FIRST || q.rx_sub == `VOTE_MID)) begin
            next_q.rx_votes = vsum;
          end
          take = q.sync_mode || q.rx_sub == `VOTE_LAST;
          bit_val = q.sync_mode ? rx_in : vsum[1];
          if (q.sync_mode || q.rx_sub == `OVERSAMPLE_LAST) begin
            next_q.rx_bit_idx = q.rx_bit_idx + 4'h1;
          end
          if (take && q.rx_bit_idx != 4'h0) begin
            next_q.rx_votes = 2'b00;
            rcv[q.rx_bit_idx - 4'h1] = bit_val;
            next_q.rx_shift_reg = rcv;
            // One stop bit ends the frame whatever the transmit setting
            if (q.rx_bit_idx == len + {3'b000, par_en} + 4'h1) begin
              next_q.rx_state = RX_IDLE;
              char_done = 1'b1;
            end
          end
        end
        default: next_q.rx_state = RX_IDLE;
      endcase
    end

    if (char_done) begin
      data = (len == 4'h7) ? {2'b00, rcv[6:0]} : (len == 4'h8) ? {1'b0, rcv[7:0]} : rcv[8:0];
      ninth_in = data[8];
      if (!bit_val) begin
        next_q.framing_error_flag = 1'b1;
        next_q.rx_line_fault_flag = 1'b1;
        if (rcv == 11'h000) begin
          next_q.line_break_flag = 1'b1;
        end
      end
      // Attention mode drops 9-bit characters whose ninth bit is clear
      if (!(q.attention_enable && len == 4'h9 && !data[8])) begin
        if (next_q.rx_full_flag) begin
          next_q.overrun_flag = 1'b1;
        end
        next_q.rx_holding_buffer = data[7:0];
        next_q.rx_full_flag = 1'b1;
        if (len == 4'h9) begin
          next_q.rx_ninth_bit = data[8];
          if (data[8]) begin
            next_q.attention_enable = 1'b0;
          end
        end
        if (par_en && rcv[len] != parity_of(data, len, q.parity_sel_hi, q.tx_ninth_bit)) begin
          next_q.parity_error_flag = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.tx_empty_flag <= 1'b1;
      q.baud_divisor <= `BAUD_DIV_RESET;
      q.rx_sync1 <= 1'b1;
      q.rx_sync2 <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign tx_pin = q.tx_pin_enable ? txd : port_pin_value;
  assign ext_baud_clock_pin_out = q.baud_clk;
  assign ext_baud_clock_pin_oe_n = !q.ckx_drive;
  assign rx_irq = q.rx_full_flag && q.rx_irq_enable;
  assign tx_irq = q.tx_empty_flag && q.tx_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  tx_empty_clr_a: assert property (
    q.dp_write && q.dp_index == `IDX_TX_HOLDING |=> !q.tx_empty_flag)
    else $error("transmit-empty not cleared by buffer write");
  break_low_a: assert property (
    q.force_line_break && q.tx_pin_enable |-> !tx_pin)
    else $error("transmit pin not low during break");
  irq_gate_a: assert property (
    $rose(q.tx_empty_flag) && q.tx_irq_enable |-> tx_irq)
    else $error("transmit interrupt not pending");
  err_clear_a: assert property (
    rd_status && !char_done |=> !q.overrun_flag && !q.framing_error_flag
      && !q.parity_error_flag)
    else $error("error flags survive status read");
  rx_full_clr_a: assert property (
    rd_rxbuf && !char_done |=> !q.rx_full_flag)
    else $error("receive-full not cleared by buffer read");
  tx_done_a: assert property (
    $fell(q.tx_active_flag) |-> q.tx_empty_flag && q.tx_state == TX_IDLE)
    else $error("transmitting flag fell with data pending");
  attention_enable_clr_a: assert property (
    char_done && q.attention_enable && q.char_len_hi && ninth_in |=> !q.attention_enable)
    else $error("attention not cleared by ninth bit");
  pin_mux_a: assert property (
    !q.tx_pin_enable |-> tx_pin == port_pin_value)
    else $error("transmit pin overrides port pin");
  char_fill_a: assert property (
    char_done && !q.attention_enable |=> q.rx_full_flag)
    else $error("received character did not set receive-full");

  rx_char_c: cover property (char_done);
  tx_frame_c: cover property ($fell(q.tx_active_flag));
  break_c: cover property (q.line_break_flag);
  overrun_c: cover property (q.overrun_flag);

endmodule : usart_control_status_core

//--- serial_peer.sv
// Purpose: remote serial device facing the transmit and receive lines
// Assumes: asynchronous framing, divisor 1, so sixteen hclk per bit
// Notes: the line idles high between frames
`timescale 1ns/100ps

module serial_peer (
  input wire logic hclk,
  input wire logic from_dut,
  output logic to_dut
);
  initial to_dut = 1'b1;

  // LSB first; the last bit sent stays on the line
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      to_dut <= b[i];
      repeat (16) @(posedge hclk);
    end
  endtask : send

  // Samples at the centre of each bit, start bit included
  task automatic get(input int n, output logic [11:0] b);
    b = '0;
    while (from_dut !== 1'b0) @(posedge hclk);
    repeat (8) @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      b[i] = from_dut;
      repeat (16) @(posedge hclk);
    end
  endtask : get
endmodule : serial_peer

//--- usart_control_status_core_tb.sv
// Purpose: self-checking bench for the serial core
// Assumes: zero-wait bus slave, baud divisor 1
// Notes: register rows first, then framing, errors and pin cases
`timescale 1ns/100ps
`include "usart_consts.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

module usart_control_status_core_tb;
  import usart_pkg::*;
  typedef struct {logic [11:0] idx; logic [31:0] wd; logic [31:0] ex;} row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_pin, tx_pin, port_pin_value;
  logic rx_irq, tx_irq, ext_clk, ext_run, ckx_out, ckx_oe_n;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [11:0] fb;
  logic [3:0] par;
  int n_fail, tests_run, cycles;
  row_t rows [7];

  usart_control_status_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .port_pin_value(port_pin_value),
    .ext_baud_clock_pin_in(ext_clk), .ext_baud_clock_pin_out(ckx_out),
    .ext_baud_clock_pin_oe_n(ckx_oe_n), .rx_irq(rx_irq), .tx_irq(tx_irq));
  serial_peer peer (.hclk(hclk), .from_dut(tx_pin), .to_dut(rx_pin));

  ////////////////////////////////////////////////////////////////
  always #4 hclk = ~hclk;

  // External clock pin: stands still unless a test lets it run
  always @(posedge hclk) begin
    if (ext_run) begin
      ext_clk <= ~ext_clk;
    end
  end

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] idx, input logic [31:0] v);
    bus(1'b1, idx, v, rd);
  endtask : wr

  task automatic chk_reg(input logic [11:0] idx, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, idx, 32'h0, rd);
    `CHK(rd & m, e)
  endtask : chk_reg

  ////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    port_pin_value = 1'b1;
    ext_clk = 1'b0;
    ext_run = 1'b0;
    par = {1'b0, 1'b1, ^8'h5A, ~^8'h5A};
    // Upper write bits must read back as zero; the fourth row's index is unmapped
    rows = '{'{`IDX_IRQ_CLOCK, 32'hFFFF_FFA5, 32'hA5}, '{`IDX_CTRL_STATUS, 32'hFF, 32'hF9},
      '{`IDX_RX_STATUS, 32'hFF, 32'h04}, '{12'h0C0, 32'hFF, 32'h0},
      '{`IDX_IRQ_CLOCK, 32'h0, 32'h0}, '{`IDX_CTRL_STATUS, 32'h0, 32'h1},
      '{`IDX_RX_STATUS, 32'h0, 32'h0}};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk_reg(`IDX_CTRL_STATUS, 32'hFFFF_FFFF, 32'h1);
    chk_reg(`IDX_RX_STATUS, 32'hFF, 32'h0);
    chk_reg(`IDX_IRQ_CLOCK, 32'hFF, 32'h0);
    `CHK(tx_irq, 1'b0)
    `CHK(hresp, 1'b0)
    `CHK(ckx_oe_n, 1'b1)
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].idx, rows[i].wd);
      chk_reg(rows[i].idx, 32'hFFFF_FFFF, rows[i].ex);
    end
    wr(`IDX_BAUD_CFG, 32'h1);
    // The port pin is already an output before the transmit pin is switched in
    wr(`IDX_IRQ_CLOCK, 32'h21);
    repeat (2) @(posedge hclk);
    `CHK(tx_irq, 1'b1)
    for (int m = 0; m < 4; m++) begin
      wr(`IDX_CTRL_STATUS, 32'h80 | (m << 5));
      wr(`IDX_TX_HOLDING, 32'h5A);
      peer.get(11, fb);
      `CHK(fb[10:0], {1'b1, par[m], 8'h5A, 1'b0})
      chk_reg(`IDX_RX_STATUS, 32'h2, 32'h0);
    end
    // Two stop bits keep the transmitter busy one bit longer than one would
    wr(`IDX_IRQ_CLOCK, 32'hA1);
    wr(`IDX_CTRL_STATUS, 32'h0);
    wr(`IDX_TX_HOLDING, 32'h5A);
    peer.get(10, fb);
    `CHK(fb[9:0], {1'b1, 8'h5A, 1'b0})
    chk_reg(`IDX_RX_STATUS, 32'h2, 32'h2);
    wr(`IDX_CTRL_STATUS, 32'h08);
    wr(`IDX_TX_HOLDING, 32'hD5);
    peer.get(9, fb);
    `CHK(fb[8:0], {1'b1, 7'h55, 1'b0})
    wr(`IDX_CTRL_STATUS, 32'h0);
    wr(`IDX_IRQ_CLOCK, 32'h22);
    peer.send({3'b111, 8'h3C, 1'b0}, 11);
    repeat (4) @(posedge hclk);
    `CHK(rx_irq, 1'b1)
    chk_reg(`IDX_RX_HOLDING, 32'hFF, 32'h3C);
    `CHK(rx_irq, 1'b0)
    peer.send({3'b111, 8'h11, 1'b0}, 11);
    peer.send({3'b111, 8'h22, 1'b0}, 11);
    chk_reg(`IDX_RX_STATUS, 32'hF0, 32'h80);
    chk_reg(`IDX_RX_HOLDING, 32'hFF, 32'h22);
    // Stop bit low: framing fault, summarised by the global flag
    peer.send({2'b11, 1'b0, 8'hA5, 1'b0}, 12);
    chk_reg(`IDX_CTRL_STATUS, 32'h4, 32'h4);
    chk_reg(`IDX_RX_STATUS, 32'h70, 32'h40);
    chk_reg(`IDX_RX_STATUS, 32'hF0, 32'h0);
    chk_reg(`IDX_CTRL_STATUS, 32'h4, 32'h0);
    peer.send(12'h000, 10);
    repeat (4) @(posedge hclk);
    chk_reg(`IDX_RX_STATUS, 32'h11, 32'h11);
    peer.send(12'h001, 1);
    chk_reg(`IDX_RX_STATUS, 32'h11, 32'h0);
    repeat (200) @(posedge hclk);
    bus(1'b0, `IDX_RX_HOLDING, 32'h0, rd);
    wr(`IDX_CTRL_STATUS, 32'h10);
    wr(`IDX_RX_STATUS, 32'h4);
    // Ninth bit clear: dropped while attention mode is on
    peer.send({2'b11, 1'b0, 8'h66, 1'b0}, 11);
    chk_reg(`IDX_CTRL_STATUS, 32'h2, 32'h0);
    peer.send({3'b111, 8'h99, 1'b0}, 12);
    chk_reg(`IDX_RX_STATUS, 32'hC, 32'h8);
    chk_reg(`IDX_RX_HOLDING, 32'hFF, 32'h99);
    // Loopback with a zero ninth bit, so the earlier one must be replaced
    wr(`IDX_CTRL_STATUS, 32'h18);
    wr(`IDX_TX_HOLDING, 32'hC3);
    repeat (250) @(posedge hclk);
    chk_reg(`IDX_RX_HOLDING, 32'hFF, 32'hC3);
    chk_reg(`IDX_RX_STATUS, 32'h8, 32'h0);
    // Synchronous transmit clocked from the pin: frozen until the pin runs
    wr(`IDX_CTRL_STATUS, 32'h0);
    wr(`IDX_IRQ_CLOCK, 32'h34);
    wr(`IDX_TX_HOLDING, 32'h5A);
    repeat (40) @(posedge hclk);
    `CHK(tx_pin, 1'b0)
    ext_run <= 1'b1;
    repeat (40) @(posedge hclk);
    ext_run <= 1'b0;
    chk_reg(`IDX_RX_STATUS, 32'h2, 32'h0);
    wr(`IDX_BAUD_CFG, 32'h0001_0001);
    @(posedge hclk);
    `CHK(ckx_oe_n, 1'b0)
    fb[0] = ckx_out;
    @(posedge hclk);
    `CHK(ckx_out, ~fb[0])
    wr(`IDX_BAUD_CFG, 32'h1);
    wr(`IDX_IRQ_CLOCK, 32'h0);
    port_pin_value <= 1'b0;
    @(posedge hclk);
    `CHK(tx_pin, 1'b0)
    port_pin_value <= 1'b1;
    @(posedge hclk);
    `CHK(tx_pin, 1'b1)
    wr(`IDX_IRQ_CLOCK, 32'h60);
    @(posedge hclk);
    `CHK(tx_pin, 1'b0)
    wr(`IDX_IRQ_CLOCK, 32'h20);
    @(posedge hclk);
    `CHK(tx_pin, 1'b1)
    close_out();
  end
endmodule : usart_control_status_core_tb
